// >>> common/sample_status_pkg.sv
package sample_status_pkg;
	// register addresses on the register access port
	localparam logic [7:0] ADDR_STATUS_ALIAS     = 8'h00;
	localparam logic [7:0] ADDR_FIFO_DATA        = 8'h01;
	localparam logic [7:0] ADDR_PRESSURE_HIGH    = 8'h01;
	localparam logic [7:0] ADDR_TEMPERATURE_HIGH = 8'h04;
	localparam logic [7:0] ADDR_SAMPLE_STATUS    = 8'h06;

	// fifo mode field values
	localparam logic [1:0] FIFO_MODE_OFF = 2'h0;

	// status byte bit positions
	localparam int BIT_ANY_OW  = 7;
	localparam int BIT_PRES_OW = 6;
	localparam int BIT_TEMP_OW = 5;
	localparam int BIT_RSVD_HI = 4;
	localparam int BIT_ANY_RDY = 3;
	localparam int BIT_PRES_RDY = 2;
	localparam int BIT_TEMP_RDY = 1;
	localparam int BIT_RSVD_LO = 0;

	// flag vector indices and count
	localparam int FLAG_COUNT    = 6;
	localparam int IDX_TEMP_RDY  = 0;
	localparam int IDX_PRES_RDY  = 1;
	localparam int IDX_ANY_RDY   = 2;
	localparam int IDX_TEMP_OW   = 3;
	localparam int IDX_PRES_OW   = 4;
	localparam int IDX_ANY_OW    = 5;

	// reset values
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] RDATA_RESET  = 8'h00;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
	localparam logic       FLAG_RESET   = 1'b0;
endpackage

// >>> logic/flag_cell.sv
`timescale 1ns/1ps
// sticky flag: set wins over clear in the same cycle
module flag_cell (
	input  wire logic mclk,
	input  wire logic reset,
	input  wire logic set,
	input  wire logic clear,
	output logic      flag
);
	logic flag_ff;
	logic nxt_flag;

	// next value: set beats clear
	assign nxt_flag = set | (flag_ff & ~clear);
	assign flag     = flag_ff;

	// flag storage
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			flag_ff <= sample_status_pkg::FLAG_RESET;
		end else begin
			flag_ff <= nxt_flag;
		end
	end
endmodule

// >>> logic/sample_status_flags.sv
`timescale 1ns/1ps
// Function
// - status byte reads at its own address and at alias address zero
// - with fifo mode zero the status tracks each sample register update
// - bit 7 sets when either channel completes while bit 3 is still set
// - bit 7 clears on read of pressure or temperature high byte
// - bit 6 sets when pressure completes before previous pressure was retrieved
// - bit 6 clears on read of pressure high byte
// - bit 5 sets when temperature completes before previous temperature retrieved
// - bit 5 clears on read of temperature high byte
// - bit 3 sets when either channel has a new acquisition
// - bit 3 clears on read of either high byte
// - bit 2 sets on every completed pressure acquisition while pressure event enable is one
// - bit 2 clears on read of pressure high byte
// - bit 1 sets on temperature completion, clears on temperature high read
// - with fifo mode nonzero all flags clear on fifo data port read
// - pressure flags only generated while pressure event enable is one
// - temperature flags only generated while temperature event enable is one
// - combined flags only generated while data ready event enable is set
// - address zero returns sample status in mode zero, fifo status otherwise
module sample_status_flags (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       pressure_done,
	input  wire logic       temperature_done,
	input  wire logic       pressure_event_flag_enable,
	input  wire logic       temperature_event_flag_enable,
	input  wire logic       data_ready_event_enable,
	input  wire logic [1:0] fifo_mode,
	input  wire logic [7:0] fifo_status,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	output logic      [7:0] reg_rdata,
	output logic            reg_rvalid,
	output logic            reg_hit,
	output logic      [7:0] sample_status
);
	// decoded read strobes
	logic       fifo_off;
	logic       rd_pres_high;
	logic       rd_temp_high;
	logic       rd_fifo_data;
	logic       rd_alias;
	logic       rd_status;
	logic       addr_mapped;

	// event qualification
	logic       pres_evt;
	logic       temp_evt;
	logic       pres_clr;
	logic       temp_clr;
	logic       any_clr;
	logic       pres_ow_evt;
	logic       temp_ow_evt;

	// flag vector and its controls
	logic [sample_status_pkg::FLAG_COUNT-1:0] flag_set;
	logic [sample_status_pkg::FLAG_COUNT-1:0] flag_clr;
	logic [sample_status_pkg::FLAG_COUNT-1:0] flags;
	logic [7:0] status_byte;

	// read path
	logic [7:0] nxt_rdata;
	logic       nxt_hit;
	logic [7:0] rdata_ff;
	logic       rvalid_ff;
	logic       hit_ff;
	logic [7:0] status_ff;

	// address decode of host reads
	assign fifo_off     = (fifo_mode == sample_status_pkg::FIFO_MODE_OFF);
	assign rd_pres_high = reg_rd & fifo_off & (reg_addr == sample_status_pkg::ADDR_PRESSURE_HIGH);
	assign rd_temp_high = reg_rd & fifo_off & (reg_addr == sample_status_pkg::ADDR_TEMPERATURE_HIGH);
	assign rd_fifo_data = reg_rd & ~fifo_off & (reg_addr == sample_status_pkg::ADDR_FIFO_DATA);
	assign rd_alias     = (reg_addr == sample_status_pkg::ADDR_STATUS_ALIAS);
	assign rd_status    = (reg_addr == sample_status_pkg::ADDR_SAMPLE_STATUS);
	assign addr_mapped  = rd_alias | rd_status;

	assign pres_evt = pressure_done & pressure_event_flag_enable;
	assign temp_evt = temperature_done & temperature_event_flag_enable;

	assign pres_clr = rd_pres_high | rd_fifo_data;
	assign temp_clr = rd_temp_high | rd_fifo_data;
	assign any_clr  = rd_pres_high | rd_temp_high | rd_fifo_data;

	assign pres_ow_evt = pres_evt & flags[sample_status_pkg::IDX_PRES_RDY] & ~pres_clr;
	assign temp_ow_evt = temp_evt & flags[sample_status_pkg::IDX_TEMP_RDY] & ~temp_clr;

	assign flag_set[sample_status_pkg::IDX_PRES_RDY] = pres_evt;
	assign flag_set[sample_status_pkg::IDX_TEMP_RDY] = temp_evt;
	assign flag_set[sample_status_pkg::IDX_ANY_RDY]  = data_ready_event_enable & (pressure_done | temperature_done);
	assign flag_set[sample_status_pkg::IDX_PRES_OW]  = pres_ow_evt;
	assign flag_set[sample_status_pkg::IDX_TEMP_OW]  = temp_ow_evt;
	assign flag_set[sample_status_pkg::IDX_ANY_OW]   = data_ready_event_enable & flags[sample_status_pkg::IDX_ANY_RDY]
		& (pressure_done | temperature_done) & ~any_clr;

	assign flag_clr[sample_status_pkg::IDX_PRES_RDY] = pres_clr;
	assign flag_clr[sample_status_pkg::IDX_PRES_OW]  = pres_clr;
	assign flag_clr[sample_status_pkg::IDX_TEMP_RDY] = temp_clr;
	assign flag_clr[sample_status_pkg::IDX_TEMP_OW]  = temp_clr;
	assign flag_clr[sample_status_pkg::IDX_ANY_RDY]  = any_clr;
	assign flag_clr[sample_status_pkg::IDX_ANY_OW]   = any_clr;

	// one sticky cell per flag
	genvar gi;
	generate
		for (gi = 0; gi < sample_status_pkg::FLAG_COUNT; gi = gi + 1) begin : g_flag
			flag_cell u_flag (
				.mclk  (mclk),
				.reset (reset),
				.set   (flag_set[gi]),
				.clear (flag_clr[gi]),
				.flag  (flags[gi])
			);
		end
	endgenerate

	assign status_byte[sample_status_pkg::BIT_ANY_OW]   = flags[sample_status_pkg::IDX_ANY_OW];
	assign status_byte[sample_status_pkg::BIT_PRES_OW]  = flags[sample_status_pkg::IDX_PRES_OW];
	assign status_byte[sample_status_pkg::BIT_TEMP_OW]  = flags[sample_status_pkg::IDX_TEMP_OW];
	assign status_byte[sample_status_pkg::BIT_RSVD_HI]  = 1'b0;
	assign status_byte[sample_status_pkg::BIT_ANY_RDY]  = flags[sample_status_pkg::IDX_ANY_RDY];
	assign status_byte[sample_status_pkg::BIT_PRES_RDY] = flags[sample_status_pkg::IDX_PRES_RDY];
	assign status_byte[sample_status_pkg::BIT_TEMP_RDY] = flags[sample_status_pkg::IDX_TEMP_RDY];
	assign status_byte[sample_status_pkg::BIT_RSVD_LO]  = 1'b0;

	// status at own address and alias
	assign nxt_rdata = rd_status ? status_byte :
		rd_alias ? (fifo_off ? status_byte : fifo_status) : sample_status_pkg::RDATA_UNMAPPED;
	assign nxt_hit   = addr_mapped;

	// read data register, one cycle after the strobe
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rdata_ff  <= sample_status_pkg::RDATA_RESET;
			rvalid_ff <= 1'b0;
			hit_ff    <= 1'b0;
		end else begin
			rvalid_ff <= reg_rd;
			if (reg_rd) begin
				rdata_ff <= nxt_rdata;
				hit_ff   <= nxt_hit;
			end
		end
	end

	// live status image for the sample side
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			status_ff <= sample_status_pkg::STATUS_RESET;
		end else begin
			status_ff <= status_byte;
		end
	end

	assign reg_rdata     = rdata_ff;
	assign reg_rvalid    = rvalid_ff;
	assign reg_hit       = hit_ff;
	assign sample_status = status_ff;

	// checks on flag behaviour and the read path
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	AST_P_READY_SET: assert property (pres_evt |=> flags[sample_status_pkg::IDX_PRES_RDY])
		else $error("pressure ready not set after completion");

	AST_P_READY_CLR: assert property (rd_pres_high && !pressure_done |=>
		!flags[sample_status_pkg::IDX_PRES_RDY] && !flags[sample_status_pkg::IDX_PRES_OW])
		else $error("pressure flags not cleared by high byte read");

	AST_T_READY_CLR: assert property (rd_temp_high && !temperature_done |=>
		!flags[sample_status_pkg::IDX_TEMP_RDY] && !flags[sample_status_pkg::IDX_TEMP_OW])
		else $error("temperature flags not cleared by high byte read");

	AST_FIFO_CLR: assert property (rd_fifo_data && !pressure_done && !temperature_done |=>
		status_byte == sample_status_pkg::STATUS_RESET)
		else $error("fifo port read left a flag set");

	AST_P_GATE: assert property (!pressure_event_flag_enable throughout
		(!flags[sample_status_pkg::IDX_PRES_RDY] ##1 1'b1) |-> !flags[sample_status_pkg::IDX_PRES_RDY])
		else $error("pressure ready rose while disabled");

	AST_T_GATE: assert property (!flags[sample_status_pkg::IDX_TEMP_OW] && !temperature_event_flag_enable
		|=> !flags[sample_status_pkg::IDX_TEMP_OW])
		else $error("temperature overwrite rose while disabled");

	AST_ANY_GATE: assert property (!data_ready_event_enable && !flags[sample_status_pkg::IDX_ANY_RDY]
		|=> !$rose(flags[sample_status_pkg::IDX_ANY_RDY]))
		else $error("combined ready rose while disabled");

	AST_P_OW_SET: assert property (pres_evt && flags[sample_status_pkg::IDX_PRES_RDY] && !pres_clr
		|=> flags[sample_status_pkg::IDX_PRES_OW] && flags[sample_status_pkg::IDX_PRES_RDY])
		else $error("pressure overwrite not flagged");

	AST_T_OW_SET: assert property (temp_evt && flags[sample_status_pkg::IDX_TEMP_RDY] && !temp_clr
		|=> flags[sample_status_pkg::IDX_TEMP_OW])
		else $error("temperature overwrite not flagged");

	AST_ANY_OW_SET: assert property (data_ready_event_enable && flags[sample_status_pkg::IDX_ANY_RDY]
		&& (pressure_done || temperature_done) && !any_clr |=> flags[sample_status_pkg::IDX_ANY_OW])
		else $error("combined overwrite not flagged");

	AST_ANY_CLR: assert property (any_clr && !pressure_done && !temperature_done |=>
		!flags[sample_status_pkg::IDX_ANY_OW] && !flags[sample_status_pkg::IDX_ANY_RDY])
		else $error("combined flags not cleared by high byte read");

	AST_ANY_RDY_SET: assert property (data_ready_event_enable && temperature_done
		|=> flags[sample_status_pkg::IDX_ANY_RDY])
		else $error("combined ready not set");

	AST_ALIAS_READ: assert property (reg_rd && rd_alias && fifo_off |=>
		reg_rvalid && reg_hit && reg_rdata == $past(status_byte))
		else $error("alias read did not return sample status");

	AST_FIFO_ALIAS: assert property (reg_rd && rd_alias && !fifo_off |=> reg_rdata == $past(fifo_status))
		else $error("alias read did not return fifo status");

	AST_OWN_READ: assert property (reg_rd && rd_status |=> reg_rdata == $past(status_byte) ##1
		sample_status == $past(status_byte))
		else $error("status read or image mismatch");

	AST_RESERVED: assert property (!sample_status[sample_status_pkg::BIT_RSVD_HI]
		&& !sample_status[sample_status_pkg::BIT_RSVD_LO])
		else $error("reserved status bit set");

	// further checks on set paths, gating, same-edge clears and the read port
	AST_T_READY_SET: assert property (temp_evt |=> flags[sample_status_pkg::IDX_TEMP_RDY])
		else $error("temperature ready not set after completion");

	AST_ANY_RDY_PSET: assert property (data_ready_event_enable && pressure_done
		|=> flags[sample_status_pkg::IDX_ANY_RDY])
		else $error("combined ready not set by pressure");

	AST_P_OW_GATE: assert property (!flags[sample_status_pkg::IDX_PRES_OW] && !pressure_event_flag_enable
		|=> !flags[sample_status_pkg::IDX_PRES_OW])
		else $error("pressure overwrite rose while disabled");

	AST_T_RDY_GATE: assert property (!flags[sample_status_pkg::IDX_TEMP_RDY] && !temperature_event_flag_enable
		|=> !flags[sample_status_pkg::IDX_TEMP_RDY])
		else $error("temperature ready rose while disabled");

	AST_ANY_OW_GATE: assert property (!flags[sample_status_pkg::IDX_ANY_OW] && !data_ready_event_enable
		|=> !flags[sample_status_pkg::IDX_ANY_OW])
		else $error("combined overwrite rose while disabled");

	AST_P_SET_WINS: assert property (pres_evt && pres_clr |=>
		flags[sample_status_pkg::IDX_PRES_RDY] && !flags[sample_status_pkg::IDX_PRES_OW])
		else $error("pressure completion lost against a clear");

	AST_T_SET_WINS: assert property (temp_evt && temp_clr |=>
		flags[sample_status_pkg::IDX_TEMP_RDY] && !flags[sample_status_pkg::IDX_TEMP_OW])
		else $error("temperature completion lost against a clear");

	AST_ANY_SET_WINS: assert property (data_ready_event_enable && (pressure_done || temperature_done) && any_clr
		|=> flags[sample_status_pkg::IDX_ANY_RDY] && !flags[sample_status_pkg::IDX_ANY_OW])
		else $error("combined completion lost against a clear");

	AST_STICKY: assert property (flag_clr == '0 |=> (flags & $past(flags)) == $past(flags))
		else $error("flag dropped without a clear");

	AST_STATUS_KEEPS: assert property (reg_rd && addr_mapped |=> (flags & $past(flags)) == $past(flags))
		else $error("status read cleared a flag");

	AST_FIFO_T_HIGH: assert property (reg_rd && !fifo_off
		&& reg_addr == sample_status_pkg::ADDR_TEMPERATURE_HIGH |=> (flags & $past(flags)) == $past(flags))
		else $error("temperature high read cleared a flag in fifo mode");

	AST_UNMAPPED: assert property (reg_rd && !addr_mapped |=> reg_rvalid && !reg_hit
		&& reg_rdata == sample_status_pkg::RDATA_UNMAPPED)
		else $error("unmapped read returned data");

	AST_RVALID_ONE: assert property (!reg_rd |=> !reg_rvalid)
		else $error("read valid without a strobe");

	AST_P_HIGH_T_KEEP: assert property (rd_pres_high |=>
		!$fell(flags[sample_status_pkg::IDX_TEMP_RDY]) && !$fell(flags[sample_status_pkg::IDX_TEMP_OW]))
		else $error("pressure high read cleared temperature flags");

	AST_T_HIGH_P_KEEP: assert property (rd_temp_high |=>
		!$fell(flags[sample_status_pkg::IDX_PRES_RDY]) && !$fell(flags[sample_status_pkg::IDX_PRES_OW]))
		else $error("temperature high read cleared pressure flags");

	// main scenarios
	COV_ANY_SAME_EDGE: cover property (flag_set[sample_status_pkg::IDX_ANY_RDY] && any_clr);
	COV_P_OVERWRITE: cover property (pres_evt ##[1:20] pres_ow_evt);
	COV_ALIAS_THEN_HIGH: cover property (reg_rd && rd_alias ##1 rd_pres_high);
	COV_FIFO_CLEAR: cover property (flags[sample_status_pkg::IDX_ANY_OW] ##1 rd_fifo_data);
	COV_SET_AND_CLEAR: cover property (pres_evt && pres_clr);
endmodule

// >>> testbench/host_model.sv
`timescale 1ns/1ps
// host side of the read port: one byte per strobe
module host_model (
	input  wire logic       mclk,
	output logic            reg_rd,
	output logic      [7:0] reg_addr,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid,
	input  wire logic       reg_hit
);
	initial begin
		reg_rd = 1'b0;
		reg_addr = 8'h00;
	end
	// strobe stands for the taking edge only; answer read once that edge has landed
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h, output logic v);
		@(posedge mclk);
		#1 reg_rd = 1'b1;
		reg_addr = a;
		@(posedge mclk);
		#1 reg_rd = 1'b0;
		reg_addr = ~a; // stale address is not left on the port
		v = reg_rvalid;
		d = reg_rdata;
		h = reg_hit;
	endtask
endmodule

// >>> testbench/sample_status_flags_tb_top.sv
`timescale 1ns/1ps
// randomized bench with a fixed corner sequence first
module sample_status_flags_tb_top;
	logic       mclk, reset, pd, td, pe, te, de, rd, rvalid, hit, h, v;
	logic [1:0] fm;
	logic [7:0] fs, rdata, sstat, raddr, d;
	logic       pr, tr, ar, po, to, ao;
	int         err_count, cmp_count, cyc;

	sample_status_flags dut (.mclk(mclk), .reset(reset), .pressure_done(pd), .temperature_done(td),
		.pressure_event_flag_enable(pe), .temperature_event_flag_enable(te),
		.data_ready_event_enable(de), .fifo_mode(fm), .fifo_status(fs), .reg_rd(rd), .reg_addr(raddr),
		.reg_rdata(rdata), .reg_rvalid(rvalid), .reg_hit(hit), .sample_status(sstat));
	host_model host (.mclk(mclk), .reg_rd(rd), .reg_addr(raddr), .reg_rdata(rdata),
		.reg_rvalid(rvalid), .reg_hit(hit));

	initial mclk = 1'b0;
	always #20 mclk = ~mclk;

	// hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			results();
		end
	end

	function automatic logic [7:0] exp_status();
		return {ao, po, to, 1'b0, ar, pr, tr, 1'b0};
	endfunction
	function automatic logic [7:0] exp_rdata(input logic [7:0] a);
		if (a == 8'h00 && fm != 2'h0)
			return fs;
		return (a == 8'h00 || a == 8'h06) ? exp_status() : 8'h00;
	endfunction

	task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] s);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cmp_bit(input string n, input logic e, input logic s);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %b seen %b", n, e, s);
		end
	endtask

	// one acquisition step, then the registered status copy is checked
	task automatic ev(input logic p, input logic t);
		@(posedge mclk);
		#1 pd = p;
		td = t;
		@(posedge mclk);
		#1 pd = 1'b0;
		td = 1'b0;
		// model moves after any read clear of the same edge
		#1;
		if (p && pe) begin
			po = po | pr;
			pr = 1'b1;
		end
		if (t && te) begin
			to = to | tr;
			tr = 1'b1;
		end
		if ((p || t) && de) begin
			ao = ao | ar;
			ar = 1'b1;
		end
		repeat (2) @(posedge mclk);
		#1 cmp_byte("sample_status", exp_status(), sstat);
	endtask

	// one host read: data is the status before any clear
	task automatic rdchk(input logic [7:0] a);
		logic [7:0] e;
		e = exp_rdata(a);
		host.rd(a, d, h, v);
		cmp_bit("reg_rvalid", 1'b1, v);
		cmp_byte("reg_rdata", e, d);
		cmp_bit("reg_hit", (a == 8'h00 || a == 8'h06), h);
		if (fm == 2'h0 && a == 8'h01)
			{pr, po, ar, ao} = 4'h0;
		if (fm == 2'h0 && a == 8'h04)
			{tr, to, ar, ao} = 4'h0;
		if (fm != 2'h0 && a == 8'h01)
			{pr, po, tr, to, ar, ao} = 6'h00;
		repeat (2) @(posedge mclk);
		#1 cmp_byte("sample_status", exp_status(), sstat);
	endtask

	// acquisition on the edge of a host read: set beats clear, cleared channel gets no overwrite
	task automatic evrd(input logic p, input logic t, input logic [7:0] a);
		fork
			rdchk(a);
			ev(p, t);
		join
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		{pd, td, pe, te, de, pr, tr, ar, po, to, ao} = 11'h0;
		fm = 2'h0;
		fs = 8'h5a;
		reset = 1'b1;
		void'($urandom(32'hf9f4));
		repeat (4) @(posedge mclk);
		#1 reset = 1'b0;
		cmp_byte("sample_status", 8'h00, sstat);
		// corners: double acquisitions, disabled channels, both high bytes, fifo data port
		ev(1'b1, 1'b0);
		{pe, te, de} = 3'b111;
		ev(1'b1, 1'b0);
		ev(1'b1, 1'b1);
		ev(1'b0, 1'b1);
		rdchk(8'h06);
		rdchk(8'h00);
		rdchk(8'h01);
		rdchk(8'h04);
		ev(1'b1, 1'b1);
		ev(1'b1, 1'b1);
		evrd(1'b1, 1'b1, 8'h01);
		evrd(1'b1, 1'b0, 8'h04);
		fm = 2'h1;
		rdchk(8'h00);
		rdchk(8'h04);
		rdchk(8'h01);
		evrd(1'b1, 1'b1, 8'h01);
		// random mix of acquisitions, reads and settings
		repeat (400) begin
			{pe, te, de} = 3'($urandom);
			fm = ($urandom % 3 == 0) ? 2'($urandom) : 2'h0;
			fs = 8'($urandom);
			if ($urandom % 2)
				ev(1'($urandom), 1'($urandom));
			else if ($urandom % 3)
				rdchk(8'($urandom % 9));
			else
				evrd(1'($urandom), 1'($urandom), 8'($urandom % 9));
		end
		results();
	end
endmodule
